// ### core/spct_core.sv
// Single pulse and capture timer with a classic Wishbone register slave.
//
// Our own choices: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ps
module spct_core (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic ext_trigger_pin_i,
    input wire logic capture_pin_i,
    output logic pulse_out_o,
    output logic pulse_oe_o,
    output logic timer_irq_o
);
    localparam int W = spct_pkg::CNT_W;

    spct_pkg::spct_ctrl_t ctrl_reg;
    spct_pkg::spct_ctrl_t ctrl_next;
    spct_pkg::spct_stat_t stat_reg;
    logic [W-1:0] cnt_reg;
    logic [W-1:0] cmpa_reg;
    logic [W-1:0] cmpp_reg;
    logic run_d_reg;
    logic out_reg;
    logic ack_reg;
    logic [31:0] rdat_reg;
    logic [31:0] rd_mux;
    logic [31:0] wr_val;
    logic [1:0] pin_raw;
    logic [1:0] pin_rise;
    logic [1:0] pin_fall;
    logic [1:0] mode;
    logic [1:0] act;
    logic is_pulse;
    logic is_capt;
    logic bus_req;
    logic bus_wr;
    logic run_rise;
    logic match_a;
    logic pulse_end;
    logic trig_evt;
    logic src_rise;
    logic src_fall;
    logic cap_evt;
    logic p_wrap;
    logic clr_a;
    logic clr_p;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        return a[7:2] == ofs[7:2];
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[8*i +: 8] = new_v[8*i +: 8];
            end
        end
        return r;
    endfunction

    // Index 0 is the trigger pin, index 1 the capture pin.
    assign pin_raw = {capture_pin_i, ext_trigger_pin_i};

    // The capture pin is watched even while pulse_oe_o drives it.
    genvar g;
    for (g = 0; g < 2; g++) begin : g_sync
        logic [2:0] sh_reg;
        logic lvl_reg;
        logic prev_reg;
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                sh_reg <= spct_pkg::SYNC_RST;
                lvl_reg <= 1'b0;
                prev_reg <= 1'b0;
            end else begin
                sh_reg <= {sh_reg[1:0], pin_raw[g]};
                if (sh_reg[1] == sh_reg[2]) begin
                    lvl_reg <= sh_reg[2];
                end
                prev_reg <= lvl_reg;
            end
        end
        assign pin_rise[g] = lvl_reg & ~prev_reg;
        assign pin_fall[g] = ~lvl_reg & prev_reg;
    end

    assign mode = {ctrl_reg.timer_mode_sel_hi, ctrl_reg.timer_mode_sel_lo};
    assign act = {ctrl_reg.pin_action_sel_hi, ctrl_reg.pin_action_sel_lo};
    assign is_pulse = mode == spct_pkg::MODE_PULSE;
    assign is_capt = mode == spct_pkg::MODE_CAPTURE;

    // Register bus: ack one cycle after the request, write on the ack edge.
    assign bus_req = wb_cyc_i & wb_stb_i;
    assign bus_wr = bus_req & wb_we_i & ack_reg;
    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdat_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= bus_req & ~ack_reg;
        end
    end

    always_comb begin
        rd_mux = spct_pkg::DAT_RST;
        if (hit(wb_adr_i, spct_pkg::OFS_CTRL)) begin
            rd_mux[spct_pkg::CTRL_W-1:0] = ctrl_reg;
        end else if (hit(wb_adr_i, spct_pkg::OFS_CMPA)) begin
            rd_mux[W-1:0] = cmpa_reg;
        end else if (hit(wb_adr_i, spct_pkg::OFS_CMPP)) begin
            rd_mux[W-1:0] = cmpp_reg;
        end else if (hit(wb_adr_i, spct_pkg::OFS_COUNT)) begin
            rd_mux[W-1:0] = cnt_reg;
        end else if (hit(wb_adr_i, spct_pkg::OFS_STATUS)) begin
            rd_mux[1:0] = stat_reg;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdat_reg <= spct_pkg::DAT_RST;
        end else if (bus_req & ~ack_reg) begin
            rdat_reg <= rd_mux;
        end
    end

    assign wr_val = merge(rd_mux, wb_dat_i, wb_sel_i);

    // Timer events; the compare matches skip the run-rise cycle, the count is stale then.
    assign run_rise = ctrl_reg.counter_run & ~run_d_reg;
    assign match_a = cnt_reg == cmpa_reg;
    assign pulse_end = is_pulse & ctrl_reg.counter_run & ~run_rise
                       & match_a;
    assign trig_evt = is_pulse & pin_rise[0];
    assign src_rise = ctrl_reg.capture_src_sel ? pin_rise[0]
                                               : pin_rise[1];
    assign src_fall = ctrl_reg.capture_src_sel ? pin_fall[0]
                                               : pin_fall[1];
    always_comb begin
        unique case (act)
            spct_pkg::ACT_RISE: cap_evt = src_rise;
            spct_pkg::ACT_FALL: cap_evt = src_fall;
            spct_pkg::ACT_BOTH: cap_evt = src_rise | src_fall;
            spct_pkg::ACT_NONE: cap_evt = 1'b0;
        endcase
        cap_evt = cap_evt & is_capt;
    end
    // Compare P of zero lets the count wrap from the all-ones value.
    assign p_wrap = is_capt & ctrl_reg.counter_run & ~run_rise
                    & ((cmpp_reg != spct_pkg::CNT_RST) ? cnt_reg == cmpp_reg
                       : cnt_reg == spct_pkg::CNT_MAX);

    // A trigger edge wins over a match or a write in the same cycle.
    always_comb begin
        ctrl_next = ctrl_reg;
        if (bus_wr && hit(wb_adr_i, spct_pkg::OFS_CTRL)) begin
            ctrl_next = wr_val[spct_pkg::CTRL_W-1:0];
        end
        if (pulse_end) begin
            ctrl_next.counter_run = 1'b0;
        end
        if (trig_evt) begin
            ctrl_next.counter_run = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_reg <= spct_pkg::CTRL_RST;
            run_d_reg <= 1'b0;
        end else begin
            ctrl_reg <= ctrl_next;
            run_d_reg <= ctrl_reg.counter_run;
        end
    end

    // Compare P and the clear select bit play no part in pulse mode.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_reg <= spct_pkg::CNT_RST;
        end else if (run_rise) begin
            cnt_reg <= spct_pkg::CNT_RST;
        end else if (p_wrap) begin
            cnt_reg <= spct_pkg::CNT_RST;
        end else if (ctrl_reg.counter_run & (is_capt | is_pulse)) begin
            cnt_reg <= cnt_reg + 10'h001;
        end
    end

    // A capture beats a software write to compare A in the same cycle.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cmpa_reg <= spct_pkg::CNT_RST;
        end else if (cap_evt) begin
            cmpa_reg <= cnt_reg;
        end else if (bus_wr && hit(wb_adr_i, spct_pkg::OFS_CMPA)) begin
            cmpa_reg <= wr_val[W-1:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cmpp_reg <= spct_pkg::CNT_RST;
        end else if (bus_wr && hit(wb_adr_i, spct_pkg::OFS_CMPP)) begin
            cmpp_reg <= wr_val[W-1:0];
        end
    end

    // Flags are write-one-to-clear, and a new event beats the clear.
    assign clr_a = bus_wr & hit(wb_adr_i, spct_pkg::OFS_STATUS)
                   & wr_val[spct_pkg::STAT_A_BIT];
    assign clr_p = bus_wr & hit(wb_adr_i, spct_pkg::OFS_STATUS)
                   & wr_val[spct_pkg::STAT_P_BIT];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stat_reg <= '0;
        end else begin
            stat_reg.flag_a <= (pulse_end | cap_evt)
                               | (stat_reg.flag_a & ~clr_a);
            stat_reg.flag_p <= p_wrap
                               | (stat_reg.flag_p & ~clr_p);
        end
    end

    assign timer_irq_o = stat_reg.flag_a | stat_reg.flag_p;

    // The run bit's next value drives the pin, so both edges line up.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            out_reg <= 1'b0;
        end else begin
            out_reg <= (ctrl_next.counter_run
                        ? ctrl_next.output_init_level
                        : ~ctrl_next.output_init_level)
                       ^ ctrl_next.output_polarity;
        end
    end

    assign pulse_out_o = out_reg;
    assign pulse_oe_o = is_pulse;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_run_clears_cnt: assert property (
        run_rise |=> cnt_reg == spct_pkg::CNT_RST)
        else $error("count not cleared at run start");

    a_pulse_lead: assert property (
        is_pulse && $rose(ctrl_reg.counter_run)
        |-> pulse_out_o == (ctrl_reg.output_init_level
                            ^ ctrl_reg.output_polarity))
        else $error("pulse leading edge missing");

    a_pulse_trail: assert property (
        is_pulse && $fell(ctrl_reg.counter_run)
        |-> pulse_out_o == (~ctrl_reg.output_init_level
                            ^ ctrl_reg.output_polarity))
        else $error("pulse trailing edge missing");

    a_match_stops_run: assert property (
        pulse_end && !trig_evt |=> !ctrl_reg.counter_run ##0 stat_reg.flag_a)
        else $error("compare A match did not stop pulse");

    a_trig_starts: assert property (
        trig_evt |=> ctrl_reg.counter_run ##1 cnt_reg == spct_pkg::CNT_RST)
        else $error("trigger edge did not start pulse");

    a_capture_copy: assert property (
        cap_evt |=> cmpa_reg == $past(cnt_reg) && stat_reg.flag_a)
        else $error("capture did not latch count");

    a_capture_off: assert property (
        is_capt && act == spct_pkg::ACT_NONE
        && !(bus_wr && hit(wb_adr_i, spct_pkg::OFS_CMPA))
        |=> cmpa_reg == $past(cmpa_reg))
        else $error("capture with edges disabled");

    a_wrap_zero: assert property (
        p_wrap |=> cnt_reg == spct_pkg::CNT_RST && stat_reg.flag_p)
        else $error("compare P did not wrap counter");

    a_free_run: assert property (
        is_capt && ctrl_reg.counter_run && !run_rise && !p_wrap
        |=> cnt_reg == W'($past(cnt_reg) + 10'h001))
        else $error("capture counter did not advance");

    a_no_drive_capt: assert property (
        is_capt |-> !pulse_oe_o)
        else $error("capture mode drives output");

    a_flag_sticky: assert property (
        stat_reg.flag_a && !clr_a |=> stat_reg.flag_a)
        else $error("flag A dropped without clear");

    c_pulse_done: cover property (pulse_end);
    c_trig_start: cover property (trig_evt ##1 ctrl_reg.counter_run);
    c_capture: cover property (cap_evt);
    c_wrap: cover property (p_wrap);
endmodule // spct_core

// ### core/spct_pkg.sv
// Package with constants and types for the single pulse and capture timer.
package spct_pkg;
    localparam int CNT_W = 10;
    localparam int CTRL_W = 9;

    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_CMPA = 8'h04;
    localparam logic [7:0] OFS_CMPP = 8'h08;
    localparam logic [7:0] OFS_COUNT = 8'h0C;
    localparam logic [7:0] OFS_STATUS = 8'h10;

    localparam int STAT_A_BIT = 0;
    localparam int STAT_P_BIT = 1;

    localparam logic [1:0] MODE_CAPTURE = 2'h1;
    localparam logic [1:0] MODE_PULSE = 2'h2;

    localparam logic [1:0] ACT_RISE = 2'h0;
    localparam logic [1:0] ACT_FALL = 2'h1;
    localparam logic [1:0] ACT_BOTH = 2'h2;
    localparam logic [1:0] ACT_NONE = 2'h3;

    localparam logic [CTRL_W-1:0] CTRL_RST = 9'h000;
    localparam logic [CNT_W-1:0] CNT_RST = 10'h000;
    localparam logic [CNT_W-1:0] CNT_MAX = 10'h3FF;
    localparam logic [2:0] SYNC_RST = 3'h0;
    localparam logic [31:0] DAT_RST = 32'h0000_0000;

    // Bit 0 is the run bit, bit 8 the output polarity.
    typedef struct packed {
        logic output_polarity;
        logic output_init_level;
        logic counter_clear_sel;
        logic capture_src_sel;
        logic pin_action_sel_hi;
        logic pin_action_sel_lo;
        logic timer_mode_sel_hi;
        logic timer_mode_sel_lo;
        logic counter_run;
    } spct_ctrl_t;

    typedef struct packed {
        logic flag_p;
        logic flag_a;
    } spct_stat_t;
endpackage

// ### verification/spct_pin_model.sv
// Behavioural model of the trigger and capture signals at the timer pins.
`timescale 1ns/1ps
module spct_pin_model (
    input wire logic clk_i,
    output logic trig_o,
    output logic cap_o
);
    initial begin
        trig_o = 1'b0;
        cap_o = 1'b0;
    end

    // Levels are held for whole clocks, since the synchroniser misses
    // edges closer together than two clocks.
    task automatic drive(input logic on_trig, input logic val, input int hold);
        @(posedge clk_i);
        if (on_trig) begin
            trig_o <= val;
        end else begin
            cap_o <= val;
        end
        repeat (hold) @(posedge clk_i);
    endtask
endmodule // spct_pin_model

// ### verification/spct_tb_top.sv
// Self-checking testbench for the single pulse and capture timer.
`timescale 1ns/1ps
module single_pulse_capture_timer_tb_top;
    localparam logic [7:0] A_CT = spct_pkg::OFS_CTRL;
    localparam logic [7:0] A_CA = spct_pkg::OFS_CMPA;
    localparam logic [7:0] A_CP = spct_pkg::OFS_CMPP;
    localparam logic [7:0] A_CN = spct_pkg::OFS_COUNT;
    localparam logic [7:0] A_ST = spct_pkg::OFS_STATUS;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat = 32'h0000_0000;
    logic [31:0] wb_dat_o;
    logic wb_ack_o, trig, cap, pulse_out_o, pulse_oe_o, timer_irq_o;
    int bad_count = 0;
    int n_checks = 0;

    always #20 clk_i = ~clk_i;

    spct_pin_model pins (.clk_i(clk_i), .trig_o(trig), .cap_o(cap));

    spct_core dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .ext_trigger_pin_i(trig), .capture_pin_i(cap),
        .pulse_out_o(pulse_out_o), .pulse_oe_o(pulse_oe_o),
        .timer_irq_o(timer_irq_o));

    task automatic chk(input string what, input logic [31:0] e,
                       input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        sel <= 4'hF;
        // Only the watchdog may end a wait for the acknowledge.
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        xfer(1'b0, a, 32'h0000_0000, q);
    endtask

    // Clear select is always set, because no mode here may heed it.
    function automatic logic [31:0] mk(logic run, logic [1:0] m,
        logic [1:0] pa, logic src, logic ini, logic pol);
        spct_pkg::spct_ctrl_t c;
        c = spct_pkg::CTRL_RST;
        c.counter_run = run;
        {c.timer_mode_sel_hi, c.timer_mode_sel_lo} = m;
        {c.pin_action_sel_hi, c.pin_action_sel_lo} = pa;
        c.capture_src_sel = src;
        c.counter_clear_sel = 1'b1;
        c.output_init_level = ini;
        c.output_polarity = pol;
        return {23'h0, c};
    endfunction

    task automatic width(output int w);
        #1;
        w = 0;
        while (pulse_out_o === 1'b1 && w < 300) begin
            @(posedge clk_i);
            #1;
            w++;
        end
    endtask

    task automatic t_reset();
        logic [31:0] q;
        chk("oe at reset", 0, pulse_oe_o);
        chk("irq at reset", 0, timer_irq_o);
        rd(A_CT, q);
        chk("ctrl reset", 0, q);
        rd(A_CN, q);
        chk("count reset", 0, q);
        wr(8'h14, 32'hFFFF_FFFF);
        rd(8'h14, q);
        chk("unmapped", 0, q);
        wr(A_CA, 32'hFFFF_FFFF);
        rd(A_CA, q);
        chk("cmpa width", 32'h0000_03FF, q);
    endtask

    task automatic t_pulse(input logic [9:0] n);
        logic [31:0] q;
        int w;
        wr(A_CA, {22'h0, n});
        wr(A_CP, 32'h0000_0002);
        wr(A_ST, 32'h0000_0003);
        wr(A_CT, mk(1, spct_pkg::MODE_PULSE, 2'h3, 0, 1, 0));
        // The enable only updates after the acknowledge edge.
        #1;
        chk("oe in pulse", 1, pulse_oe_o);
        width(w);
        chk("pulse width", n + 2, w);
        rd(A_CT, q);
        chk("run cleared", 0, q[0]);
        rd(A_ST, q);
        chk("flag a only", 1, q[1:0]);
        repeat (3) @(posedge clk_i);
        chk("irq held", 1, timer_irq_o);
        rd(A_CN, q);
        chk("count held", 1, q[9:0] != 10'h000);
        wr(A_ST, 32'h0000_0003);
        @(posedge clk_i);
        chk("irq cleared", 0, timer_irq_o);
    endtask

    task automatic t_abort();
        logic [31:0] q;
        wr(A_CA, 32'h0000_00C8);
        wr(A_CT, mk(1, spct_pkg::MODE_PULSE, 2'h3, 0, 1, 0));
        repeat (5) @(posedge clk_i);
        wr(A_CT, mk(0, spct_pkg::MODE_PULSE, 2'h3, 0, 1, 0));
        #1;
        chk("out after clear", 0, pulse_out_o);
        rd(A_ST, q);
        chk("no flag on abort", 0, q[1:0]);
        rd(A_CN, q);
        chk("count kept", 1, q[9:0] != 10'h000);
    endtask

    task automatic t_trig();
        int w;
        wr(A_CA, 32'h0000_0004);
        wr(A_CT, mk(0, spct_pkg::MODE_PULSE, 2'h3, 0, 1, 0));
        pins.drive(1'b1, 1'b1, 0);
        w = 0;
        while (pulse_out_o !== 1'b1 && w < 12) begin
            @(posedge clk_i);
            #1;
            w++;
        end
        chk("trigger start", 1, pulse_out_o);
        width(w);
        chk("trigger width", 6, w);
        pins.drive(1'b1, 1'b0, 4);
        wr(A_ST, 32'h0000_0003);
    endtask

    task automatic t_cap(input logic [1:0] pa, input logic src);
        logic [31:0] q, c0, ca;
        wr(A_CP, 32'h0000_0000);
        wr(A_CT, mk(0, spct_pkg::MODE_CAPTURE, pa, src, 1, 1));
        wr(A_CT, mk(1, spct_pkg::MODE_CAPTURE, pa, src, 1, 1));
        wr(A_ST, 32'h0000_0003);
        rd(A_CN, c0);
        pins.drive(src, 1'b1, 6);
        rd(A_ST, q);
        chk("rise capture", pa == 2'h0 || pa == 2'h2, q[0]);
        if (q[0] === 1'b1) begin
            rd(A_CA, ca);
            chk("capture val", 1, ca[9:0] > c0[9:0]);
            chk("capture age", 1, ca[9:0] < c0[9:0] + 10'h010);
        end
        wr(A_ST, 32'h0000_0003);
        pins.drive(src, 1'b0, 6);
        rd(A_ST, q);
        chk("fall capture", pa == 2'h1 || pa == 2'h2, q[0]);
        rd(A_CN, q);
        chk("count runs", 1, q[9:0] > c0[9:0]);
        chk("no output", 0, pulse_oe_o);
    endtask

    task automatic t_wrap();
        logic [31:0] q;
        // A count already above the new limit would run to the top first.
        wr(A_CP, 32'h0000_0003);
        wr(A_CT, mk(0, spct_pkg::MODE_CAPTURE, 2'h3, 0, 1, 1));
        wr(A_CT, mk(1, spct_pkg::MODE_CAPTURE, 2'h3, 0, 1, 1));
        wr(A_ST, 32'h0000_0003);
        repeat (12) @(posedge clk_i);
        rd(A_ST, q);
        chk("wrap flag", 1, q[1]);
        rd(A_CN, q);
        chk("wrap limit", 1, q[9:0] <= 10'h003);
        wr(A_CP, 32'h0000_0000);
        wr(A_ST, 32'h0000_0003);
        repeat (12) @(posedge clk_i);
        rd(A_CN, q);
        chk("full range", 1, q[9:0] > 10'h004);
        rd(A_ST, q);
        chk("no early wrap", 0, q[1]);
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_pulse(10'h006);
        t_abort();
        t_trig();
        for (int i = 0; i < 4; i++) begin
            t_cap(2'(i), 1'b0);
        end
        t_cap(2'h0, 1'b1);
        t_wrap();
        close_out();
    end

    // The tests need about 400 clocks, so 20,000 means a hang.
    initial begin
        repeat (20000) @(posedge clk_i);
        bad_count++;
        $display("[FAIL] watchdog expected finish seen timeout");
        close_out();
    end
endmodule // single_pulse_capture_timer_tb_top
